//--- pkg/ebt_pkg.sv
/*
 * package for the 8-bit timer with one compare channel: register offsets,
 * field positions, reset values, mode and clock-select encodings, carriers.
 * assumes a classic wishbone slave with 32-bit data, byte addressed words.
 */
package ebt_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] EBT_OFS_CONTROL = 8'h00;
    localparam logic [7:0] EBT_OFS_COUNTER = 8'h04;
    localparam logic [7:0] EBT_OFS_COMPARE = 8'h08;
    localparam logic [7:0] EBT_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] EBT_OFS_MASK = 8'h10;
    localparam logic [7:0] EBT_OFS_STATUS = 8'h14;
    localparam logic [7:0] EBT_OFS_IRQACK = 8'h18;

    // control register field positions
    localparam int EBT_CTL_CS_LSB = 0;
    localparam int EBT_CTL_WGM_LSB = 3;
    localparam int EBT_CTL_COM_LSB = 5;
    localparam int EBT_CTL_FOC_BIT = 7;

    // flag and mask bit positions
    localparam int EBT_FLG_OVF_BIT = 0;
    localparam int EBT_FLG_CMP_BIT = 1;
    localparam int EBT_STS_GIE_BIT = 0;

    // counter landmarks
    localparam logic [7:0] EBT_BOTTOM = 8'h00;
    localparam logic [7:0] EBT_MAX = 8'hFF;
    localparam logic [7:0] EBT_RESET_VALUE = 8'h00;

    // prescaler taps
    localparam logic [9:0] EBT_DIV8_MASK = 10'h007;
    localparam logic [9:0] EBT_DIV64_MASK = 10'h03F;
    localparam logic [9:0] EBT_DIV256_MASK = 10'h0FF;
    localparam logic [9:0] EBT_DIV1024_MASK = 10'h3FF;

    typedef enum logic [1:0] {
        EBT_WGM_NORMAL = 2'h0,
        EBT_WGM_PHASE = 2'h1,
        EBT_WGM_CTC = 2'h2,
        EBT_WGM_FAST = 2'h3
    } ebt_wgm_type;

    typedef enum logic [2:0] {
        EBT_CS_STOP = 3'h0,
        EBT_CS_DIV1 = 3'h1,
        EBT_CS_DIV8 = 3'h2,
        EBT_CS_DIV64 = 3'h3,
        EBT_CS_DIV256 = 3'h4,
        EBT_CS_DIV1024 = 3'h5,
        EBT_CS_EXT_FALL = 3'h6,
        EBT_CS_EXT_RISE = 3'h7
    } ebt_cs_type;

    // control fields as carried through the block
    typedef struct packed {
        logic [1:0] compare_output_action;
        ebt_wgm_type waveform_mode_select;
        ebt_cs_type clock_source_select;
    } ebt_ctrl_type;

    // wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ebt_wb_req_type;

endpackage

//--- rtl/ebt_timer.sv
/*
 * 8-bit timer/counter with one compare channel, wishbone register slave,
 * clock select with prescaler and external count pin, waveform generator.
 * assumes one 10 MHz clock, synchronous active-high reset, and an external
 * count pin already synchronous to clk_i.
 */
// Function
// - counter and compare are cpu-accessible 8-bit registers
// - flag bottom at 0x00, max at 0xFF
// - top is 0xFF or compare, per mode
// - tick from prescaler or external pin edge
// - select zero stops the counter
// - counter accessible whether ticks arrive or not
// - cpu counter write beats count and clear
// - mode field picks clear/up/down per tick
// - overflow flag set per mode, may interrupt
// - equality sets compare flag next tick
// - compare irq needs enable and global bit
// - compare flag clears on ack or one-write
// - match, max, bottom drive waveform output
// - compare double buffered only in pwm modes
// - buffer loads at top (0xFF) only
// - cpu compare access hits buffer when buffered
// - force strobe updates output only, non-pwm
// - counter write blocks next tick's match
// - output state kept across mode switches
// - action field changes act immediately
// - mode 0 counts up, wraps, overflow at zero
// - mode 2 clears counter on compare match
// - mode 3 single slope, set/clear at bottom/match
// - action zero leaves output state alone
`timescale 1ns/1ps
module ebt_timer
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins and processor side
    input wire logic external_count_pin_i,
    input wire logic irq_overflow_ack_i,
    input wire logic irq_compare_ack_i,
    output logic compare_output_state_o,
    output logic bottom_o,
    output logic max_o,
    output logic irq_overflow_o,
    output logic irq_compare_o
);

    ebt_wb_req_type req;
    ebt_ctrl_type ctrl_q;
    ebt_ctrl_type ctrl_wr;
    logic [7:0] counter_value_q;
    logic [7:0] compare_value_q;
    logic [7:0] compare_buffer_q;
    logic overflow_flag_q;
    logic compare_match_flag_q;
    logic overflow_irq_enable_q;
    logic compare_irq_enable_q;
    logic global_irq_enable_q;
    logic compare_output_state_q;
    logic count_down_q;
    logic block_match_q;
    logic [9:0] prescale_q;
    logic ext_prev_q;
    logic ack_q;
    logic [31:0] rdata_q;

    logic wr_stb;
    logic wr_lane0;
    logic wr_counter;
    logic wr_compare;
    logic wr_control;
    logic wr_flags;
    logic force_strobe;
    logic [1:0] action_now;
    logic timer_tick;
    logic pwm_mode;
    logic match_raw;
    logic match;
    logic at_top;
    logic [7:0] top_value;
    logic [7:0] counter_d;
    logic count_down_d;
    logic overflow_event;
    logic reload_point;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};
    assign ctrl_wr = ebt_ctrl_type'(req.dat[6:0]);

    // bus decode; writes land on the first cycle of the strobe only
    assign wr_stb = req.cyc && req.stb && req.we && !ack_q;
    assign wr_lane0 = wr_stb && req.sel[0];
    assign wr_counter = wr_lane0 && (req.adr == EBT_OFS_COUNTER);
    assign wr_compare = wr_lane0 && (req.adr == EBT_OFS_COMPARE);
    assign wr_control = wr_lane0 && (req.adr == EBT_OFS_CONTROL);
    assign wr_flags = wr_lane0 && (req.adr == EBT_OFS_FLAGS);
    assign force_strobe = wr_control && req.dat[EBT_CTL_FOC_BIT] &&
                          ctrl_wr.waveform_mode_select != EBT_WGM_PHASE &&
                          ctrl_wr.waveform_mode_select != EBT_WGM_FAST;
    // a strobe acts with the action written beside it, not the stale one
    assign action_now = force_strobe ? ctrl_wr.compare_output_action :
                        ctrl_q.compare_output_action;

    // one-wait-state ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req.cyc && req.stb && !ack_q;
        end
    end

    // read mux; unmapped offsets read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.cyc && req.stb && !ack_q) begin
            unique case (req.adr)
                EBT_OFS_CONTROL: rdata_q <= {24'h00_0000, 1'b0, ctrl_q};
                EBT_OFS_COUNTER: rdata_q <= {24'h00_0000, counter_value_q};
                EBT_OFS_COMPARE: rdata_q <= {24'h00_0000,
                    pwm_mode ? compare_buffer_q : compare_value_q};
                EBT_OFS_FLAGS: rdata_q <= {30'h0000_0000, compare_match_flag_q,
                    overflow_flag_q};
                EBT_OFS_MASK: rdata_q <= {30'h0000_0000, compare_irq_enable_q,
                    overflow_irq_enable_q};
                EBT_OFS_STATUS: rdata_q <= {30'h0000_0000, compare_output_state_q,
                    global_irq_enable_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;

    // control register; the force bit is a strobe and is not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= '{compare_output_action: 2'h0, waveform_mode_select: EBT_WGM_NORMAL,
                        clock_source_select: EBT_CS_STOP};
        end else if (wr_control) begin
            ctrl_q <= ctrl_wr;
        end
    end

    // mask and global enable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_irq_enable_q <= 1'b0;
            compare_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
        end else begin
            if (wr_lane0 && (req.adr == EBT_OFS_MASK)) begin
                overflow_irq_enable_q <= req.dat[EBT_FLG_OVF_BIT];
                compare_irq_enable_q <= req.dat[EBT_FLG_CMP_BIT];
            end
            if (wr_lane0 && (req.adr == EBT_OFS_STATUS)) begin
                global_irq_enable_q <= req.dat[EBT_STS_GIE_BIT];
            end
        end
    end

    // prescaler free-runs so taps stay phase-coherent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale_q <= 10'h000;
            ext_prev_q <= 1'b0;
        end else begin
            prescale_q <= prescale_q + 10'h001;
            ext_prev_q <= external_count_pin_i;
        end
    end

    // clock select: one-cycle tick enable
    always_comb begin
        unique case (ctrl_q.clock_source_select)
            EBT_CS_STOP: timer_tick = 1'b0;
            EBT_CS_DIV1: timer_tick = 1'b1;
            EBT_CS_DIV8: timer_tick = (prescale_q & EBT_DIV8_MASK) == EBT_DIV8_MASK;
            EBT_CS_DIV64: timer_tick = (prescale_q & EBT_DIV64_MASK) == EBT_DIV64_MASK;
            EBT_CS_DIV256: timer_tick = (prescale_q & EBT_DIV256_MASK) == EBT_DIV256_MASK;
            EBT_CS_DIV1024: timer_tick = prescale_q == EBT_DIV1024_MASK;
            EBT_CS_EXT_FALL: timer_tick = ext_prev_q && !external_count_pin_i;
            EBT_CS_EXT_RISE: timer_tick = !ext_prev_q && external_count_pin_i;
        endcase
    end

    // landmarks and comparator
    assign pwm_mode = ctrl_q.waveform_mode_select == EBT_WGM_PHASE ||
                      ctrl_q.waveform_mode_select == EBT_WGM_FAST;
    assign bottom_o = counter_value_q == EBT_BOTTOM;
    assign max_o = counter_value_q == EBT_MAX;
    assign top_value = (ctrl_q.waveform_mode_select == EBT_WGM_CTC) ?
                       compare_value_q : EBT_MAX;
    assign at_top = counter_value_q == top_value;
    assign match_raw = counter_value_q == compare_value_q;
    assign match = match_raw && timer_tick && !block_match_q;

    // counting sequence per mode
    always_comb begin
        counter_d = counter_value_q;
        count_down_d = count_down_q;
        overflow_event = 1'b0;
        unique case (ctrl_q.waveform_mode_select)
            EBT_WGM_NORMAL: begin
                counter_d = counter_value_q + 8'h01;
                overflow_event = max_o;
            end
            EBT_WGM_CTC: begin
                counter_d = at_top ? EBT_BOTTOM : counter_value_q + 8'h01;
                overflow_event = max_o;
            end
            EBT_WGM_FAST: begin
                counter_d = counter_value_q + 8'h01;
                overflow_event = max_o;
            end
            EBT_WGM_PHASE: begin
                if (max_o) begin
                    count_down_d = 1'b1;
                end else if (bottom_o) begin
                    count_down_d = 1'b0;
                end
                counter_d = count_down_d ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
                overflow_event = bottom_o && count_down_q;
            end
        endcase
    end

    // counter register: cpu write wins over any tick action
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value_q <= EBT_RESET_VALUE;
            count_down_q <= 1'b0;
        end else if (wr_counter) begin
            counter_value_q <= req.dat[7:0];
        end else if (timer_tick) begin
            counter_value_q <= counter_d;
            count_down_q <= count_down_d;
        end
    end

    // match block held from a counter write until the next tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_match_q <= 1'b0;
        end else if (wr_counter) begin
            block_match_q <= 1'b1;
        end else if (timer_tick) begin
            block_match_q <= 1'b0;
        end
    end

    // compare value: direct or via buffer with reload at top (0xFF)
    assign reload_point = timer_tick && (ctrl_q.waveform_mode_select == EBT_WGM_FAST ?
                          max_o : (max_o && !count_down_q));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_value_q <= EBT_RESET_VALUE;
            compare_buffer_q <= EBT_RESET_VALUE;
        end else begin
            if (wr_compare) begin
                compare_buffer_q <= req.dat[7:0];
            end
            if (wr_compare && !pwm_mode) begin
                compare_value_q <= req.dat[7:0];
            end else if (pwm_mode && reload_point) begin
                compare_value_q <= compare_buffer_q;
            end
        end
    end

    // flags: set wins over one-write clear and over interrupt ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_q <= 1'b0;
            compare_match_flag_q <= 1'b0;
        end else begin
            if (timer_tick && overflow_event) begin
                overflow_flag_q <= 1'b1;
            end else if (irq_overflow_ack_i || (wr_flags && req.dat[EBT_FLG_OVF_BIT])) begin
                overflow_flag_q <= 1'b0;
            end
            if (match) begin
                compare_match_flag_q <= 1'b1;
            end else if (irq_compare_ack_i || (wr_flags && req.dat[EBT_FLG_CMP_BIT])) begin
                compare_match_flag_q <= 1'b0;
            end
        end
    end

    assign irq_compare_o = compare_match_flag_q && compare_irq_enable_q &&
                           global_irq_enable_q;
    assign irq_overflow_o = overflow_flag_q && overflow_irq_enable_q && global_irq_enable_q;

    // waveform generator; state untouched by mode writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_state_q <= 1'b0;
        end else if (action_now != 2'h0) begin
            if (force_strobe || (!pwm_mode && match)) begin
                unique case (action_now)
                    2'h1: compare_output_state_q <= !compare_output_state_q;
                    2'h2: compare_output_state_q <= 1'b0;
                    default: compare_output_state_q <= 1'b1;
                endcase
            end else if (ctrl_q.waveform_mode_select == EBT_WGM_FAST && timer_tick) begin
                if (match) begin
                    compare_output_state_q <= ctrl_q.compare_output_action[0];
                end else if (max_o) begin
                    compare_output_state_q <= !ctrl_q.compare_output_action[0];
                end
            end else if (ctrl_q.waveform_mode_select == EBT_WGM_PHASE && match) begin
                compare_output_state_q <= count_down_q ^ ctrl_q.compare_output_action[0];
            end
        end
    end
    assign compare_output_state_o = compare_output_state_q;

    property p_write_beats_tick; @(posedge clk_i) disable iff (rst_i)
        wr_counter |=> counter_value_q == $past(req.dat[7:0]);
    endproperty
    a_write_beats_tick: assert property (p_write_beats_tick)
        else $error("counter write lost");
    property p_stop; @(posedge clk_i) disable iff (rst_i)
        ctrl_q.clock_source_select == EBT_CS_STOP && !wr_counter |=> $stable(counter_value_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");
    // checker copy of the blocking window, the wait may span a whole prescale
    logic chk_block_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_block_q <= 1'b0;
        end else if (wr_counter) begin
            chk_block_q <= 1'b1;
        end else if (timer_tick) begin
            chk_block_q <= 1'b0;
        end
    end
    property p_block; @(posedge clk_i) disable iff (rst_i)
        chk_block_q && timer_tick |-> !match;
    endproperty
    a_block: assert property (p_block) else $error("blocked match fired");
    property p_cmp_flag; @(posedge clk_i) disable iff (rst_i)
        match |=> compare_match_flag_q;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("match flag not set");
    property p_irq; @(posedge clk_i) disable iff (rst_i)
        irq_compare_o |-> compare_irq_enable_q && global_irq_enable_q;
    endproperty
    a_irq: assert property (p_irq) else $error("compare irq not gated");
    property p_ctc; @(posedge clk_i) disable iff (rst_i)
        timer_tick && !wr_counter && ctrl_q.waveform_mode_select == EBT_WGM_CTC && at_top
        |=> counter_value_q == EBT_BOTTOM;
    endproperty
    a_ctc: assert property (p_ctc) else $error("ctc did not clear");
    property p_ovf_normal; @(posedge clk_i) disable iff (rst_i)
        timer_tick && !wr_counter && ctrl_q.waveform_mode_select == EBT_WGM_NORMAL && max_o
        |=> overflow_flag_q && counter_value_q == EBT_BOTTOM;
    endproperty
    a_ovf_normal: assert property (p_ovf_normal) else $error("overflow missed");
    property p_buffered; @(posedge clk_i) disable iff (rst_i)
        pwm_mode && !reload_point |=> $stable(compare_value_q);
    endproperty
    a_buffered: assert property (p_buffered) else $error("compare moved mid-period");
    property p_com_zero; @(posedge clk_i) disable iff (rst_i)
        ctrl_q.compare_output_action == 2'h0 && !force_strobe |=> $stable(compare_output_state_q);
    endproperty
    a_com_zero: assert property (p_com_zero) else $error("output moved with action zero");
    property p_force; @(posedge clk_i) disable iff (rst_i)
        force_strobe && !match |=> $stable(compare_match_flag_q) || !compare_match_flag_q;
    endproperty
    a_force: assert property (p_force) else $error("force set the flag");
    property p_force_count; @(posedge clk_i) disable iff (rst_i)
        force_strobe && !timer_tick |=> $stable(counter_value_q);
    endproperty
    a_force_count: assert property (p_force_count) else $error("force moved counter");

    c_ctc_wrap: cover property (@(posedge clk_i) timer_tick && at_top &&
        ctrl_q.waveform_mode_select == EBT_WGM_CTC);
    c_force: cover property (@(posedge clk_i) force_strobe);
    c_reload: cover property (@(posedge clk_i) pwm_mode && reload_point);
    c_phase_turn: cover property (@(posedge clk_i) timer_tick && max_o &&
        ctrl_q.waveform_mode_select == EBT_WGM_PHASE);

endmodule

//--- test/test_ebt_timer.sv
/*
 * self-checking bench for ebt_timer: register access, clock select, counting
 * modes, flags and interrupts, compare blocking, buffering, output state.
 * assumes the wishbone slave acks one cycle after taking a request.
 */
`timescale 1ns/1ps
module test_ebt_timer
    import ebt_pkg::*;
;
    // stimulus and observation
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic pin = 1'b0;
    logic ack_ovf = 1'b0;
    logic ack_cmp = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, state, bot, mx, irq_o, irq_c;
    logic [7:0] rd;
    int error_cnt = 0;
    int checks_done = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    ebt_timer uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .external_count_pin_i(pin), .irq_overflow_ack_i(ack_ovf),
        .irq_compare_ack_i(ack_cmp), .compare_output_state_o(state), .bottom_o(bot),
        .max_o(mx), .irq_overflow_o(irq_o), .irq_compare_o(irq_c)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // range check: an unknown count must never slip through as in range
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one classic cycle; held until ack is sampled high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        // no latency assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        xfer(1'b0, a, 8'h00);
        chk(rd, exp, msg);
    endtask

    function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] m,
                                       input logic [1:0] a);
        return {1'b0, a, m, cs};
    endfunction

    // bounded wait for bottom (1) or max (0)
    task automatic wait_for(input logic which);
        int n;
        n = 0;
        while ((which ? bot : mx) !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        if (n >= 600) begin
            error_cnt++;
            $display("ERROR %0t landmark never reached", $time);
        end
    endtask

    task automatic pulse_ack(input logic c);
        @(posedge clk_i);
        if (c) ack_cmp <= 1'b1;
        else ack_ovf <= 1'b1;
        @(posedge clk_i);
        ack_cmp <= 1'b0;
        ack_ovf <= 1'b0;
        tick(1);
    endtask

    task automatic t_reset;
        chk({6'h00, mx, bot}, 8'h01, "landmarks after reset");
        rd_chk(EBT_OFS_CONTROL, 8'h00, "control reset");
        rd_chk(EBT_OFS_COUNTER, 8'h00, "counter reset");
        rd_chk(EBT_OFS_COMPARE, 8'h00, "compare reset");
        rd_chk(EBT_OFS_FLAGS, 8'h00, "flags reset");
        rd_chk(EBT_OFS_IRQACK, 8'h00, "reserved word");
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00, "unmapped word");
        wr(EBT_OFS_COUNTER, 8'h5A);
        tick(20);
        rd_chk(EBT_OFS_COUNTER, 8'h5A, "stopped counter");
        wr(EBT_OFS_COMPARE, 8'hA5);
        rd_chk(EBT_OFS_COMPARE, 8'hA5, "compare readback");
    endtask

    // prescaler taps and both pin edges
    task automatic t_clock_select;
        int dv [4] = '{8, 64, 256, 1024};
        for (int i = 0; i < 6; i++) begin
            wr(EBT_OFS_COUNTER, 8'h00);
            wr(EBT_OFS_CONTROL, ctl(3'(i + 2), 2'h0, 2'h0));
            if (i < 4) tick(4 * dv[i]);
            else begin
                repeat (3) begin
                    @(posedge clk_i);
                    pin <= 1'b1;
                    tick(2);
                    @(posedge clk_i);
                    pin <= 1'b0;
                    tick(2);
                end
            end
            wr(EBT_OFS_CONTROL, 8'h00);
            xfer(1'b0, EBT_OFS_COUNTER, 8'h00);
            if (i < 4) chk_rng(rd, 8'h03, 8'h05);
            else chk(rd, 8'h03, "pin edge count");
        end
    endtask

    task automatic t_overflow;
        wr(EBT_OFS_MASK, 8'h03);
        wr(EBT_OFS_STATUS, 8'h01);
        wr(EBT_OFS_FLAGS, 8'h03);
        wr(EBT_OFS_COUNTER, 8'hF8);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h0, 2'h0));
        wait_for(1'b0);
        tick(1);
        chk({7'h00, bot}, 8'h01, "wrap after max");
        wr(EBT_OFS_CONTROL, 8'h00);
        rd_chk(EBT_OFS_FLAGS, 8'h01, "overflow flag");
        chk({7'h00, irq_o}, 8'h01, "overflow irq");
        pulse_ack(1'b0);
        rd_chk(EBT_OFS_FLAGS, 8'h00, "overflow acked");
    endtask

    task automatic t_compare;
        wr(EBT_OFS_COUNTER, 8'hA0);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h0, 2'h0));
        wr(EBT_OFS_COUNTER, 8'h40);
        xfer(1'b0, EBT_OFS_COUNTER, 8'h00);
        chk_rng(rd, 8'h40, 8'h46);
        wr(EBT_OFS_COUNTER, 8'hA0);
        tick(10);
        wr(EBT_OFS_CONTROL, 8'h00);
        rd_chk(EBT_OFS_FLAGS, 8'h02, "match flag");
        chk({7'h00, irq_c}, 8'h01, "compare irq");
        wr(EBT_OFS_STATUS, 8'h00);
        chk({7'h00, irq_c}, 8'h00, "global off");
        wr(EBT_OFS_STATUS, 8'h01);
        wr(EBT_OFS_MASK, 8'h01);
        chk({7'h00, irq_c}, 8'h00, "enable off");
        pulse_ack(1'b1);
        rd_chk(EBT_OFS_FLAGS, 8'h00, "compare acked");
        wr(EBT_OFS_COUNTER, 8'hA0);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h0, 2'h0));
        tick(10);
        wr(EBT_OFS_CONTROL, 8'h00);
        wr(EBT_OFS_FLAGS, 8'h02);
        rd_chk(EBT_OFS_FLAGS, 8'h00, "one-write clear");
        // counter written equal to compare: the first tick's match is lost
        wr(EBT_OFS_COUNTER, 8'hA5);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h0, 2'h0));
        tick(4);
        wr(EBT_OFS_CONTROL, 8'h00);
        rd_chk(EBT_OFS_FLAGS, 8'h00, "blocked match");
    endtask

    // force strobe table: control byte with strobe set, expected state
    task automatic t_force;
        logic [7:0] fc [7] = '{8'hE0, 8'hC0, 8'hA0, 8'hA0, 8'hE0, 8'h80, 8'hD8};
        logic [7:0] fe [7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
        logic [7:0] cnt;
        wr(EBT_OFS_COMPARE, 8'h10);
        xfer(1'b0, EBT_OFS_COUNTER, 8'h00);
        cnt = rd;
        for (int i = 0; i < 7; i++) begin
            wr(EBT_OFS_CONTROL, fc[i]);
            tick(1);
            chk({7'h00, state}, fe[i], "forced state");
        end
        rd_chk(EBT_OFS_STATUS, 8'h03, "state in status");
        rd_chk(EBT_OFS_FLAGS, 8'h00, "force sets no flag");
        rd_chk(EBT_OFS_COUNTER, cnt, "force keeps counter");
    endtask

    task automatic t_buffer;
        wr(EBT_OFS_COMPARE, 8'h80);
        rd_chk(EBT_OFS_COMPARE, 8'h80, "buffer readback");
        wr(EBT_OFS_COUNTER, 8'h78);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h3, 2'h2));
        tick(6);
        wr(EBT_OFS_CONTROL, ctl(3'h0, 2'h3, 2'h2));
        rd_chk(EBT_OFS_FLAGS, 8'h00, "buffer not yet active");
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h3, 2'h2));
        wait_for(1'b0);
        tick(1);
        chk({7'h00, state}, 8'h01, "set at bottom");
        tick(8'h11);
        chk({7'h00, state}, 8'h01, "old compare no longer active");
        tick(8'h74);
        chk({7'h00, state}, 8'h00, "clear on reloaded match");
        wr(EBT_OFS_CONTROL, 8'h00);
        rd_chk(EBT_OFS_FLAGS, 8'h03, "fast mode flags");
    endtask

    task automatic t_ctc_phase;
        wr(EBT_OFS_CONTROL, ctl(3'h0, 2'h2, 2'h0));
        wr(EBT_OFS_COMPARE, 8'h03);
        rd_chk(EBT_OFS_COMPARE, 8'h03, "direct compare");
        wr(EBT_OFS_COUNTER, 8'h00);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h2, 2'h0));
        repeat (8) begin
            xfer(1'b0, EBT_OFS_COUNTER, 8'h00);
            chk_rng(rd, 8'h00, 8'h03);
        end
        wr(EBT_OFS_CONTROL, 8'h00);
        wr(EBT_OFS_FLAGS, 8'h03);
        wr(EBT_OFS_COUNTER, 8'h00);
        wr(EBT_OFS_CONTROL, ctl(3'h1, 2'h1, 2'h0));
        wait_for(1'b0);
        tick(1);
        chk({6'h00, mx, bot}, 8'h00, "turns down after max");
        wait_for(1'b1);
        wr(EBT_OFS_CONTROL, 8'h00);
        xfer(1'b0, EBT_OFS_FLAGS, 8'h00);
        chk({7'h00, rd[0]}, 8'h01, "overflow at bottom");
    endtask

    task give_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run of about 6500 cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict;
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_clock_select;
        t_overflow;
        t_compare;
        t_force;
        t_buffer;
        t_ctc_phase;
        give_verdict;
    end
endmodule
